// [src/pcda_pkg.sv]
// Functional notes
// - Pointer compare subtracts memory word from pointer; only flags change.
// - Negative flag follows bit 15 of the sixteen-bit difference.
// - Zero flag set only when the whole difference is zero.
// - Overflow when sign of pointer differs from memory and result.
// - Carry is the borrow: memory word above pointer, both unsigned.
// - First-pointer compare opcodes and prefix CD, taking 4,5,6,6,7 cycles.
// - Second-pointer compare uses prefix 18 or 1A, taking 5,6,7,7,7 cycles.
// - Decimal adjust adds 00, 06, 60 or 66 to the first accumulator.
// - Low correction when low digit above nine, or half-carry with 0-3.
// - High correction and carry on prior carry, high A-F, or 9-F with A-F.
// - After adjust, accumulator holds the BCD sum, carry the hundreds.
package pcda_pkg;

    // Opcodes and prefixes
    localparam logic [7:0] OPC_LIT = 8'h8C;
    localparam logic [7:0] OPC_PAGE0 = 8'h9C;
    localparam logic [7:0] OPC_FULL = 8'hBC;
    localparam logic [7:0] OPC_OFS = 8'hAC;
    localparam logic [7:0] OPC_DECADJ = 8'h19;
    localparam logic [7:0] PRE_SECOND = 8'h18;
    localparam logic [7:0] PRE_SECOND_OFSX = 8'h1A;
    localparam logic [7:0] PRE_FIRST_OFSY = 8'hCD;

    // Flag register bit positions
    localparam int FLG_C = 0;
    localparam int FLG_V = 1;
    localparam int FLG_Z = 2;
    localparam int FLG_N = 3;
    localparam int FLG_H = 5;

    // Decimal adjust corrections and digit limits
    localparam logic [7:0] FIX_NONE = 8'h00;
    localparam logic [7:0] FIX_LO = 8'h06;
    localparam logic [7:0] FIX_HI = 8'h60;
    localparam logic [3:0] DIGIT_MAX = 4'h9;
    localparam logic [3:0] LO_HC_MAX = 4'h3;

    // Addresses
    localparam logic [15:0] ADDR_IDLE = 16'hFFFF;
    localparam logic [7:0] PAGE0_HI = 8'h00;

    // Unprefixed cycle counts; a prefix adds one
    localparam logic [3:0] CYC_LIT = 4'h4;
    localparam logic [3:0] CYC_PAGE0 = 4'h5;
    localparam logic [3:0] CYC_FULL = 4'h6;
    localparam logic [3:0] CYC_OFS = 4'h6;
    localparam logic [3:0] CYC_PREFIX = 4'h1;

    // Reset values
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [7:0] ACC_RST = 8'h00;

    typedef enum logic [1:0] {
        MODE_LIT = 2'h0,
        MODE_PAGE0 = 2'h1,
        MODE_FULL = 2'h2,
        MODE_OFS = 2'h3
    } pcda_mode_e;

    typedef struct packed {
        logic valid;
        logic decadj;
        pcda_mode_e mode;
        logic cmp_y;
        logic ofs_y;
    } pcda_dec_s;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_FETCH = 7'h02,
        ST_OPND = 7'h04,
        ST_GAP = 7'h08,
        ST_MEM = 7'h10,
        ST_FIN = 7'h20,
        ST_DAA = 7'h40
    } pcda_state_e;

    function automatic logic pcda_is_prefix(input logic [7:0] b);
        return (b == PRE_SECOND) || (b == PRE_SECOND_OFSX) ||
               (b == PRE_FIRST_OFSY);
    endfunction

    function automatic pcda_dec_s pcda_decode(input logic pre_ok,
                                              input logic [7:0] pre,
                                              input logic [7:0] opc);
        pcda_dec_s d;
        d.valid = 1'b0;
        d.decadj = 1'b0;
        d.mode = MODE_LIT;
        d.cmp_y = 1'b0;
        d.ofs_y = 1'b0;
        if (opc == OPC_DECADJ) begin
            d.decadj = !pre_ok;
        end else if (opc == OPC_LIT || opc == OPC_PAGE0 ||
                     opc == OPC_FULL) begin
            d.valid = !pre_ok || (pre == PRE_SECOND);
            d.cmp_y = pre_ok;
            if (opc == OPC_LIT) begin
                d.mode = MODE_LIT;
            end else if (opc == OPC_PAGE0) begin
                d.mode = MODE_PAGE0;
            end else begin
                d.mode = MODE_FULL;
            end
        end else if (opc == OPC_OFS) begin
            d.valid = 1'b1;
            d.mode = MODE_OFS;
            d.cmp_y = pre_ok && (pre != PRE_FIRST_OFSY);
            d.ofs_y = pre_ok && (pre != PRE_SECOND_OFSX);
        end
        return d;
    endfunction

    function automatic logic [3:0] pcda_cycles(input pcda_mode_e mode,
                                               input logic pre_ok);
        logic [3:0] base;
        base = CYC_LIT;
        unique case (mode)
            MODE_LIT: base = CYC_LIT;
            MODE_PAGE0: base = CYC_PAGE0;
            MODE_FULL: base = CYC_FULL;
            MODE_OFS: base = CYC_OFS;
        endcase
        return pre_ok ? base + CYC_PREFIX : base;
    endfunction

endpackage

// [src/pcda_alu_if.sv]
`timescale 1ns/10ps
interface pcda_alu_if;
    logic [15:0] cmp_ptr;
    logic [15:0] cmp_mem;
    logic [15:0] cmp_diff;
    logic [7:0] acc;
    logic [7:0] flags_in;
    logic [7:0] flags_cmp;
    logic [7:0] daa_acc;
    logic [7:0] flags_daa;

    modport alu (
        input cmp_ptr,
        input cmp_mem,
        input acc,
        input flags_in,
        output cmp_diff,
        output flags_cmp,
        output daa_acc,
        output flags_daa
    );

    modport core (
        output cmp_ptr,
        output cmp_mem,
        output acc,
        output flags_in,
        input cmp_diff,
        input flags_cmp,
        input daa_acc,
        input flags_daa
    );
endinterface

// [src/pcda_alu.sv]
`timescale 1ns/10ps
module pcda_alu
    import pcda_pkg::*;
(
    // Operands and results
    pcda_alu_if.alu alu_io
);

    logic [16:0] diff;
    logic lo_fix;
    logic hi_fix;
    logic [7:0] corr;
    logic [7:0] adj;

    always_comb begin
        diff = {1'b0, alu_io.cmp_ptr} - {1'b0, alu_io.cmp_mem};
        alu_io.cmp_diff = diff[15:0];
        alu_io.flags_cmp = alu_io.flags_in;
        alu_io.flags_cmp[FLG_N] = diff[15];
        alu_io.flags_cmp[FLG_Z] = (diff[15:0] == 16'h0000);
        alu_io.flags_cmp[FLG_V] =
            (alu_io.cmp_ptr[15] ^ alu_io.cmp_mem[15]) &
            (diff[15] ^ alu_io.cmp_ptr[15]);
        alu_io.flags_cmp[FLG_C] = diff[16];

        lo_fix = (alu_io.acc[3:0] > DIGIT_MAX) ||
                 (alu_io.flags_in[FLG_H] && alu_io.acc[3:0] <= LO_HC_MAX);
        hi_fix = alu_io.flags_in[FLG_C] ||
                 (alu_io.acc[7:4] > DIGIT_MAX) ||
                 (alu_io.acc[7:4] >= DIGIT_MAX &&
                  alu_io.acc[3:0] > DIGIT_MAX);
        corr = (hi_fix ? FIX_HI : FIX_NONE) | (lo_fix ? FIX_LO : FIX_NONE);
        adj = alu_io.acc + corr;
        alu_io.daa_acc = adj;
        // overflow left as is, half-carry untouched
        alu_io.flags_daa = alu_io.flags_in;
        alu_io.flags_daa[FLG_N] = adj[7];
        alu_io.flags_daa[FLG_Z] = (adj == 8'h00);
        alu_io.flags_daa[FLG_C] = hi_fix;
    end

endmodule

// [src/pcda_core.sv]
`timescale 1ns/10ps
module pcda_core
    import pcda_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Instruction start
    input wire logic op_start,
    input wire logic [15:0] op_pc,
    // Processor state
    input wire logic [15:0] first_pointer_reg,
    input wire logic [15:0] second_pointer_reg,
    input wire logic [7:0] first_accumulator,
    input wire logic [7:0] flags_in,
    // Memory bus
    input wire logic [7:0] bus_rdata,
    output logic [15:0] bus_addr_ff,
    output logic bus_read_ff,
    // Results
    output logic [7:0] flag_register_ff,
    output logic flag_we_ff,
    output logic [7:0] acc_result_ff,
    output logic acc_we_ff,
    output logic done_ff,
    output logic illegal_ff,
    output logic busy_ff
);

    ////////////////////////////////////////////////////////////////////
    pcda_alu_if alu_io ();

    pcda_state_e state_ff, nxt_state;
    logic [15:0] nxt_addr;
    logic [15:0] pc_ff, nxt_pc;
    logic [7:0] pre_ff, nxt_pre;
    logic pre_ok_ff, nxt_pre_ok;
    pcda_dec_s dec_ff, nxt_dec;
    logic cnt_ff, nxt_cnt;
    logic [15:0] opnd_ff, nxt_opnd;
    logic [15:0] word_ff, nxt_word;
    logic [7:0] nxt_flags;
    logic nxt_flag_we;
    logic [7:0] nxt_acc;
    logic nxt_acc_we;
    logic nxt_done;
    logic nxt_illegal;
    pcda_dec_s dec;
    logic [15:0] opnd_word;
    logic [15:0] ofs_ptr;

    assign alu_io.cmp_ptr = dec_ff.cmp_y ? second_pointer_reg :
                                           first_pointer_reg;
    assign alu_io.cmp_mem = word_ff;
    assign alu_io.acc = first_accumulator;
    assign alu_io.flags_in = flags_in;
    assign ofs_ptr = dec_ff.ofs_y ? second_pointer_reg : first_pointer_reg;

    pcda_alu u_alu (
        .alu_io(alu_io)
    );

    ////////////////////////////////////////////////////////////////////
    // Sequencer: one state per bus cycle kind
    always_comb begin
        nxt_state = state_ff;
        nxt_addr = bus_addr_ff;
        nxt_pc = pc_ff;
        nxt_pre = pre_ff;
        nxt_pre_ok = pre_ok_ff;
        nxt_dec = dec_ff;
        nxt_cnt = cnt_ff;
        nxt_opnd = opnd_ff;
        nxt_word = word_ff;
        nxt_flags = flag_register_ff;
        nxt_flag_we = 1'b0;
        nxt_acc = acc_result_ff;
        nxt_acc_we = 1'b0;
        nxt_done = 1'b0;
        nxt_illegal = 1'b0;
        dec = pcda_decode(pre_ok_ff, pre_ff, bus_rdata);
        opnd_word = {opnd_ff[7:0], bus_rdata};
        unique case (state_ff)
            ST_IDLE: begin
                nxt_addr = ADDR_IDLE;
                // Start is ignored while an instruction runs
                if (op_start) begin
                    nxt_state = ST_FETCH;
                    nxt_addr = op_pc;
                    nxt_pc = op_pc + 16'h0001;
                    nxt_pre_ok = 1'b0;
                end
            end
            ST_FETCH: begin
                if (!pre_ok_ff && pcda_is_prefix(bus_rdata)) begin
                    nxt_pre = bus_rdata;
                    nxt_pre_ok = 1'b1;
                    nxt_addr = pc_ff;
                    nxt_pc = pc_ff + 16'h0001;
                end else if (dec.decadj) begin
                    nxt_dec = dec;
                    nxt_state = ST_DAA;
                    nxt_addr = pc_ff;
                end else if (!dec.valid) begin
                    nxt_illegal = 1'b1;
                    nxt_done = 1'b1;
                    nxt_state = ST_IDLE;
                    nxt_addr = ADDR_IDLE;
                end else begin
                    nxt_dec = dec;
                    nxt_state = ST_OPND;
                    nxt_addr = pc_ff;
                    nxt_pc = pc_ff + 16'h0001;
                    nxt_cnt = (dec.mode == MODE_LIT) ||
                              (dec.mode == MODE_FULL);
                end
            end
            ST_OPND: begin
                nxt_opnd = opnd_word;
                if (cnt_ff) begin
                    nxt_cnt = 1'b0;
                    nxt_addr = pc_ff;
                    nxt_pc = pc_ff + 16'h0001;
                end else begin
                    nxt_cnt = 1'b1;
                    unique case (dec_ff.mode)
                        MODE_LIT: begin
                            nxt_word = opnd_word;
                            nxt_state = ST_FIN;
                            nxt_addr = ADDR_IDLE;
                        end
                        MODE_PAGE0: begin
                            nxt_state = ST_MEM;
                            nxt_addr = {PAGE0_HI, bus_rdata};
                        end
                        MODE_FULL: begin
                            nxt_state = ST_MEM;
                            nxt_addr = opnd_word;
                        end
                        MODE_OFS: begin
                            nxt_state = ST_GAP;
                            nxt_addr = ADDR_IDLE;
                        end
                    endcase
                end
            end
            ST_GAP: begin
                nxt_state = ST_MEM;
                nxt_addr = ofs_ptr + {8'h00, opnd_ff[7:0]};
            end
            ST_MEM: begin
                // High byte first, then low byte
                nxt_word = {word_ff[7:0], bus_rdata};
                if (cnt_ff) begin
                    nxt_cnt = 1'b0;
                    nxt_addr = bus_addr_ff + 16'h0001;
                end else begin
                    nxt_state = ST_FIN;
                    nxt_addr = ADDR_IDLE;
                end
            end
            ST_FIN: begin
                // only the flags are written back
                nxt_flags = alu_io.flags_cmp;
                nxt_flag_we = 1'b1;
                nxt_done = 1'b1;
                nxt_state = ST_IDLE;
                nxt_addr = ADDR_IDLE;
            end
            ST_DAA: begin
                nxt_flags = alu_io.flags_daa;
                nxt_flag_we = 1'b1;
                nxt_acc = alu_io.daa_acc;
                nxt_acc_we = 1'b1;
                nxt_done = 1'b1;
                nxt_state = ST_IDLE;
                nxt_addr = ADDR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_ff <= ST_IDLE;
            bus_addr_ff <= ADDR_IDLE;
            bus_read_ff <= 1'b1;
            pc_ff <= 16'h0000;
            pre_ff <= 8'h00;
            pre_ok_ff <= 1'b0;
            dec_ff <= '0;
            cnt_ff <= 1'b0;
            opnd_ff <= 16'h0000;
            word_ff <= 16'h0000;
            flag_register_ff <= FLAGS_RST;
            flag_we_ff <= 1'b0;
            acc_result_ff <= ACC_RST;
            acc_we_ff <= 1'b0;
            done_ff <= 1'b0;
            illegal_ff <= 1'b0;
            busy_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            bus_addr_ff <= nxt_addr;
            bus_read_ff <= 1'b1;
            pc_ff <= nxt_pc;
            pre_ff <= nxt_pre;
            pre_ok_ff <= nxt_pre_ok;
            dec_ff <= nxt_dec;
            cnt_ff <= nxt_cnt;
            opnd_ff <= nxt_opnd;
            word_ff <= nxt_word;
            flag_register_ff <= nxt_flags;
            flag_we_ff <= nxt_flag_we;
            acc_result_ff <= nxt_acc;
            acc_we_ff <= nxt_acc_we;
            done_ff <= nxt_done;
            illegal_ff <= nxt_illegal;
            busy_ff <= (nxt_state != ST_IDLE);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Cycle counter, read only by the checks below
    logic [3:0] cyc_ff;
    logic cmp_ff;
    // Reference difference for the flag checks, apart from the ALU
    logic [15:0] chk_diff;

    assign chk_diff = alu_io.cmp_ptr - word_ff;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cyc_ff <= 4'h0;
            cmp_ff <= 1'b0;
        end else begin
            if (state_ff == ST_IDLE && op_start) begin
                cyc_ff <= 4'h1;
            end else if (state_ff != ST_IDLE && nxt_state != ST_IDLE) begin
                cyc_ff <= cyc_ff + 4'h1;
            end
            cmp_ff <= (state_ff == ST_FIN);
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    x_cycles_a: assert property (
        cmp_ff && !dec_ff.cmp_y |->
            cyc_ff == pcda_cycles(dec_ff.mode, pre_ok_ff))
        else $error("first pointer compare cycle count wrong");

    y_cycles_a: assert property (
        cmp_ff && dec_ff.cmp_y |->
            cyc_ff == pcda_cycles(dec_ff.mode, pre_ok_ff) && pre_ok_ff)
        else $error("second pointer compare cycle count wrong");

    idle_addr_a: assert property (
        (state_ff == ST_GAP || state_ff == ST_FIN) |->
            bus_addr_ff == ADDR_IDLE && bus_read_ff)
        else $error("internal cycle not on all-ones address");

    neg_flag_a: assert property (
        state_ff == ST_FIN |=>
            flag_we_ff && flag_register_ff[FLG_N] == $past(chk_diff[15]) &&
            $past(alu_io.cmp_diff) == $past(chk_diff))
        else $error("negative flag not bit 15 of difference");

    zero_flag_a: assert property (
        state_ff == ST_FIN |=> flag_register_ff[FLG_Z] ==
            ($past(alu_io.cmp_ptr) == $past(word_ff)))
        else $error("zero flag wrong after compare");

    ovf_flag_a: assert property (
        state_ff == ST_FIN |=> flag_register_ff[FLG_V] ==
            ($past(alu_io.cmp_ptr[15]) != $past(word_ff[15]) &&
             $past(chk_diff[15]) != $past(alu_io.cmp_ptr[15])))
        else $error("overflow flag wrong after compare");

    borrow_flag_a: assert property (
        state_ff == ST_FIN |=> flag_register_ff[FLG_C] ==
            ($past(word_ff) > $past(alu_io.cmp_ptr)) && !acc_we_ff)
        else $error("carry flag is not the borrow");

    daa_low_a: assert property (
        state_ff == ST_DAA && first_accumulator[3:0] > DIGIT_MAX |=>
            acc_result_ff[3:0] == $past(first_accumulator[3:0]) + 4'h6)
        else $error("low digit correction missing");

    daa_carry_a: assert property (
        state_ff == ST_DAA |=> flag_register_ff[FLG_C] ==
            ($past(flags_in[FLG_C]) || $past(first_accumulator[7:4]) > 4'h9
             || ($past(first_accumulator[7:4]) >= 4'h9 &&
                 $past(first_accumulator[3:0]) > 4'h9)))
        else $error("carry after decimal adjust wrong");

    daa_bcd_a: assert property (
        state_ff == ST_DAA && first_accumulator[3:0] <= DIGIT_MAX &&
        first_accumulator[7:4] <= DIGIT_MAX && !flags_in[FLG_C] &&
        !flags_in[FLG_H] |=>
            acc_we_ff && acc_result_ff == $past(first_accumulator) &&
            !flag_register_ff[FLG_C])
        else $error("valid BCD value altered by adjust");

    daa_flags_a: assert property (
        state_ff == ST_DAA |=>
            flag_register_ff[FLG_N] == acc_result_ff[7] &&
            flag_register_ff[FLG_Z] == (acc_result_ff == 8'h00) &&
            flag_register_ff[FLG_H] == $past(flags_in[FLG_H]))
        else $error("flags after decimal adjust wrong");

endmodule

// [tb/tb_top.sv]
`timescale 1ns/10ps
module tb_top
    import pcda_pkg::*;
;
    ////////////////////////////////////////////////////////////////////////
    // Stimulus tables: prefix, opcode, compared and offset pointer, cycles
    localparam logic [7:0] F_PRE [10] = '{8'h00, 8'h00, 8'h00, 8'h00,
        PRE_FIRST_OFSY, PRE_SECOND, PRE_SECOND, PRE_SECOND,
        PRE_SECOND_OFSX, PRE_SECOND};
    localparam logic [7:0] F_OPC [10] = '{OPC_LIT, OPC_PAGE0, OPC_FULL,
        OPC_OFS, OPC_OFS, OPC_LIT, OPC_PAGE0, OPC_FULL, OPC_OFS, OPC_OFS};
    localparam bit F_Y [10] = '{0, 0, 0, 0, 0, 1, 1, 1, 1, 1};
    localparam bit F_OY [10] = '{0, 0, 0, 0, 1, 0, 0, 0, 0, 1};
    localparam int F_N [10] = '{4, 5, 6, 6, 7, 5, 6, 7, 7, 7};
    // Equal, borrow, both overflow signs, plain
    localparam logic [15:0] D_PTR [5] = '{16'h1234, 16'h0001, 16'h8000,
        16'h7FFF, 16'h4000};
    localparam logic [15:0] D_MEM [5] = '{16'h1234, 16'h0002, 16'h0001,
        16'hFFFF, 16'h1000};
    localparam logic [7:0] BCD_V [6] = '{8'h00, 8'h09, 8'h15, 8'h45,
        8'h58, 8'h99};

    ////////////////////////////////////////////////////////////////////////
    logic clk_sys = 1'b0;
    logic rst;
    logic op_start;
    logic [15:0] op_pc;
    logic [15:0] first_pointer_reg;
    logic [15:0] second_pointer_reg;
    logic [7:0] first_accumulator;
    logic [7:0] flags_in;
    logic [7:0] bus_rdata;
    logic [15:0] bus_addr_ff;
    logic bus_read_ff;
    logic [7:0] flag_register_ff;
    logic flag_we_ff;
    logic [7:0] acc_result_ff;
    logic acc_we_ff;
    logic done_ff;
    logic illegal_ff;
    logic busy_ff;
    logic [7:0] mem [0:65535];
    int failures = 0;
    int n_checks = 0;

    always #5 clk_sys = ~clk_sys;
    // Memory answers in the same cycle as the address
    assign bus_rdata = mem[bus_addr_ff];

    pcda_core i_pcda_core (
        .clk_sys(clk_sys), .rst(rst), .op_start(op_start), .op_pc(op_pc),
        .first_pointer_reg(first_pointer_reg),
        .second_pointer_reg(second_pointer_reg),
        .first_accumulator(first_accumulator), .flags_in(flags_in),
        .bus_rdata(bus_rdata), .bus_addr_ff(bus_addr_ff),
        .bus_read_ff(bus_read_ff), .flag_register_ff(flag_register_ff),
        .flag_we_ff(flag_we_ff), .acc_result_ff(acc_result_ff),
        .acc_we_ff(acc_we_ff), .done_ff(done_ff), .illegal_ff(illegal_ff),
        .busy_ff(busy_ff)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Starts one instruction and returns in its done cycle
    task automatic run_op(input logic [15:0] pc, input int n,
                          input bit idle_chk);
        int i;
        @(posedge clk_sys);
        op_start <= 1'b1;
        op_pc <= pc;
        @(posedge clk_sys);
        op_start <= 1'b0;
        #1;
        for (i = 1; i < 20 && done_ff !== 1'b1; i++) begin
            check("bus_read_ff", 16'(bus_read_ff), 16'h0001);
            check("busy", 16'(busy_ff), 16'h0001);
            if (i == 1) check("first addr", bus_addr_ff, pc);
            if (idle_chk && i == n)
                check("idle addr", bus_addr_ff, ADDR_IDLE);
            @(posedge clk_sys);
            #1;
        end
        if (i == 20) begin
            failures++;
            complete_run();
        end
        check("cycles", 16'(i), 16'(n + 1));
        check("busy end", 16'(busy_ff), 16'h0000);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic test_compare();
        logic [15:0] p, m, o, r, k, ea;
        logic [3:0] e4;
        for (int f = 0; f < 10; f++) begin
            for (int d = 0; d < 5; d++) begin
                @(posedge clk_sys);
                p = D_PTR[d];
                m = D_MEM[d];
                // Other pointer differs so a wrong pick shows in the flags
                o = p + 16'h0300;
                first_pointer_reg <= F_Y[f] ? o : p;
                second_pointer_reg <= F_Y[f] ? p : o;
                k = 16'h0100;
                if (F_PRE[f] != 8'h00) begin
                    mem[k] = F_PRE[f];
                    k++;
                end
                mem[k] = F_OPC[f];
                k++;
                ea = k;
                if (F_OPC[f] == OPC_PAGE0) begin
                    mem[k] = 8'h40;
                    ea = 16'h0040;
                end else if (F_OPC[f] == OPC_FULL) begin
                    mem[k] = 8'h20;
                    mem[k + 1] = 8'h00;
                    ea = 16'h2000;
                end else if (F_OPC[f] == OPC_OFS) begin
                    mem[k] = 8'hF0;
                    ea = ((F_OY[f] == F_Y[f]) ? p : o) + 16'h00F0;
                end
                mem[ea] = m[15:8];
                mem[ea + 1] = m[7:0];
                r = p - m;
                e4 = {r[15], r == 16'h0000,
                      (p[15] & ~m[15] & ~r[15]) | (~p[15] & m[15] & r[15]),
                      m > p};
                // Stale flag bits start inverted so missing writes show
                flags_in <= {4'hD, ~e4};
                run_op(16'h0100, F_N[f], 1'b1);
                check("flag_we", 16'(flag_we_ff), 16'h0001);
                check("cmp flags", 16'(flag_register_ff),
                      16'({4'hD, e4}));
            end
        end
        $display("test_compare finished");
    endtask

    task automatic test_decadj();
        logic [8:0] s;
        logic h;
        logic [7:0] er, fi, ef;
        int dec;
        for (int i = 0; i < 6; i++) begin
            for (int j = 0; j < 6; j++) begin
                for (int c = 0; c < 2; c++) begin
                    @(posedge clk_sys);
                    s = {1'b0, BCD_V[i]} + {1'b0, BCD_V[j]} + 9'(c);
                    h = ({1'b0, BCD_V[i][3:0]} + {1'b0, BCD_V[j][3:0]}
                         + 5'(c)) > 5'h0F;
                    dec = BCD_V[i][7:4] * 10 + BCD_V[i][3:0]
                        + BCD_V[j][7:4] * 10 + BCD_V[j][3:0] + c;
                    er = 8'((dec % 100 / 10) * 16 + dec % 10);
                    fi = 8'h82;
                    fi[FLG_H] = h;
                    fi[FLG_C] = s[8];
                    fi[FLG_N] = ~er[7];
                    fi[FLG_Z] = er != 8'h00;
                    ef = fi;
                    ef[FLG_N] = er[7];
                    ef[FLG_Z] = er == 8'h00;
                    ef[FLG_C] = dec >= 100;
                    first_accumulator <= s[7:0];
                    flags_in <= fi;
                    mem[16'h0100] = OPC_DECADJ;
                    run_op(16'h0100, 2, 1'b0);
                    check("acc_we", 16'(acc_we_ff), 16'h0001);
                    check("acc", 16'(acc_result_ff),
                          16'(er));
                    check("adj flags", 16'(flag_register_ff),
                          16'(ef));
                end
            end
        end
        $display("test_decadj finished");
    endtask

    // Unknown opcode, then a prefix that does not fit its opcode
    task automatic test_illegal();
        mem[16'h0100] = 8'h01;
        run_op(16'h0100, 1, 1'b0);
        check("illegal", 16'(illegal_ff), 16'h0001);
        check("no flag write", 16'(flag_we_ff), 16'h0000);
        mem[16'h0100] = PRE_SECOND_OFSX;
        mem[16'h0101] = OPC_LIT;
        run_op(16'h0100, 2, 1'b0);
        check("illegal pre", 16'(illegal_ff), 16'h0001);
        check("no flag write", 16'(flag_we_ff), 16'h0000);
        $display("test_illegal finished");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        op_start = 1'b0;
        op_pc = 16'h0000;
        first_pointer_reg = 16'h0000;
        second_pointer_reg = 16'h0000;
        first_accumulator = 8'h00;
        flags_in = 8'h00;
        for (int a = 0; a < 65536; a++) mem[a] = 8'hA5;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        #1;
        check("reset addr", bus_addr_ff, ADDR_IDLE);
        check("reset read", 16'(bus_read_ff), 16'h0001);
        test_compare();
        test_decadj();
        test_illegal();
        complete_run();
    end
endmodule
